// File: hw/host_if_select.sv
// host interface strap latch, pin direction control and memory map decode
//
// Operation
// - serial output tri-stated while chip select high
// - serial mode: parallel pins off, straps 2,3 kept on 64-pin, none on 44-pin
// - parallel mode straps latched once like interface strap
// - 44-pin: strap0 low mode 5, high 6
// - 64-pin strap3 low: straps 2,4 pick 1-4
// - 64-pin strap3 high: straps 2,1 pick 5,6,9,10
// - modes 1,2: 15 address, 8 data lines
// - modes 3,4: 14 address, 16 data lines
// - modes 5,6: muxed 15-bit address, 8-bit data
// - modes 9,10: muxed 16 lines, byte strobes
// - shared lines are inputs while chip select low
// - pins unused by mode are high impedance
// - chip select pull-up serial, pull-down parallel
// - serial registers: 160 bytes, four 32-byte banks
// - registers also reachable by 8-bit unbanked address
// - main memory 32K, sram at 0000h-5FFFh
// - crypto 7800h-7C4Fh, dma only
// - phy space 32 words, management path only
// - sram 12K x 16 words, byte writable
// - sram indirect always, direct on parallel
// - three address spaces serial, two parallel
// - interface strap high serial, low parallel
// - straps sampled 1 us after reset release
`timescale 1ns/1ps
`include "host_if_params.svh"

module host_if_select
    import host_if_pkg::*;
#(
    parameter bit PINS64 = 1'b1  // 64-pin variant when set, 44-pin otherwise
)
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // power-up straps
    input  wire logic        interfaceSelectStrap,
    input  wire logic [4:0]  parallelModeStraps,
    // chip select pin and serial data out
    input  wire logic        csPin,
    input  wire logic        spiSoDrive,
    input  wire logic        spiSoData,
    output logic             soOut,
    output logic             soOe,
    output logic             spiInEn,
    output logic             csPullUpEn,
    output logic             csPullDownEn,
    output logic             csActive,
    // parallel pin control
    input  wire logic        parReadDrive,
    input  wire logic [15:0] parReadData,
    output logic [15:0]      adOut,
    output logic [15:0]      adOe,
    output logic [15:0]      adInEn,
    output logic [14:0]      addrInEn,
    output logic [3:0]       ctlInEn,
    output logic [4:0]       strapInEn,
    // selection status
    output logic             selDone,
    output logic             serialMode,
    output mode_t            modeSel,
    output logic             wideData,
    output logic             muxedBus,
    output logic             rwSelectStyle,
    output logic [1:0]       addrSpaces,
    // control register address from the serial engine
    input  wire logic        regUnbanked,
    input  wire logic [1:0]  regBank,
    input  wire logic [7:0]  regAddr,
    output logic [7:0]       regLinearQ,
    output logic             regHitQ,
    // main memory access
    input  wire logic        memReq,
    input  wire logic        memFromDma,
    input  wire logic        memDirect,
    input  wire logic [15:0] memAddr,
    output region_t          memRegionQ,
    output logic [13:0]      sramWordQ,
    output logic [1:0]       sramLaneQ,
    output logic             memGrantQ,
    output logic             memDenyQ,
    // phy register access
    input  wire logic        phyReq,
    input  wire logic        phyFromMgmt,
    input  wire logic [5:0]  phyAddr,
    output logic             phyGrantQ,
    output logic             phyDenyQ
);

    // =====================================================================
    // functions
    // =====================================================================

    // strap decode to a parallel mode number
    function automatic mode_t decodeMode(input logic pins64, input logic [4:0] s);
        mode_t m;
        m = MODE_5;
        if (!pins64)
            m = s[`STRAP_BIT0] ? MODE_6 : MODE_5;
        else if (!s[`STRAP_BIT3])
        begin
            case ({s[`STRAP_BIT2], s[`STRAP_BIT4]})
                2'b00:   m = MODE_1;
                2'b01:   m = MODE_2;
                2'b10:   m = MODE_3;
                default: m = MODE_4;
            endcase
        end
        else
        begin
            case ({s[`STRAP_BIT2], s[`STRAP_BIT1]})
                2'b00:   m = MODE_5;
                2'b01:   m = MODE_6;
                2'b10:   m = MODE_9;
                default: m = MODE_10;
            endcase
        end
        return m;
    endfunction

    // classify a 16-bit main memory byte address
    function automatic region_t regionOf(input logic [15:0] a, input logic ser);
        region_t r;
        if (a <= `SRAM_LAST)
            r = REG_SRAM;
        else if (a >= `CRYPTO_FIRST && a <= `CRYPTO_LAST)
            r = REG_CRYPTO;
        else if (!ser && a >= `PAR_REG_BASE)
            r = REG_CTRL;
        else
            r = REG_UNUSED;
        return r;
    endfunction

    // =====================================================================
    // strap latch sequence
    // =====================================================================

    localparam int DELAY_CYC = `STRAP_DELAY_CYC;

    state_t     stateQ;        // latch sequence state
    logic [5:0] delayCntQ;     // cycles since reset release
    logic       serialQ;       // latched interface choice
    mode_t      modeQ;         // latched mode number

    // wait out the power-up delay, then latch once and stay
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stateQ    <= ST_WAIT;
            delayCntQ <= 6'h00;
        end
        else
        begin
            case (stateQ)
                ST_WAIT:
                begin
                    // straps settle before sampling
                    if (delayCntQ == 6'(DELAY_CYC - 1))
                        stateQ <= ST_LATCH;
                    else
                        delayCntQ <= delayCntQ + 6'h01;
                end
                ST_LATCH: stateQ <= ST_RUN;
                ST_RUN:   stateQ <= ST_RUN;
                default:  stateQ <= ST_WAIT;
            endcase
        end
    end

    // capture the straps in the single latch cycle; never again until reset
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            serialQ <= 1'b1;
            modeQ   <= MODE_SERIAL;
        end
        else if (stateQ == ST_LATCH)
        begin
            serialQ <= interfaceSelectStrap;
            // both straps taken on the same edge, the same way
            modeQ   <= interfaceSelectStrap ? MODE_SERIAL : decodeMode(PINS64, parallelModeStraps);
        end
    end

    assign selDone    = (stateQ == ST_RUN);
    assign serialMode = serialQ;
    assign modeSel    = modeQ;

    // =====================================================================
    // mode properties
    // =====================================================================

    logic parOn;   // a parallel mode is live
    logic wide;    // 16-bit data modes
    logic muxed;   // address shares the data lines
    logic rwSel;   // read/write select plus enable or byte selects

    always_comb
    begin
        parOn = selDone && !serialQ;
        wide  = (modeQ == MODE_3) || (modeQ == MODE_4) || (modeQ == MODE_9) || (modeQ == MODE_10);
        muxed = (modeQ == MODE_5) || (modeQ == MODE_6) || (modeQ == MODE_9) || (modeQ == MODE_10);
        rwSel = (modeQ == MODE_2) || (modeQ == MODE_4) || (modeQ == MODE_6) || (modeQ == MODE_10);
    end

    assign wideData      = parOn && wide;
    assign muxedBus      = parOn && muxed;
    assign rwSelectStyle = parOn && rwSel;
    // serial keeps a separate register space
    assign addrSpaces    = !selDone ? 2'd0 : (serialQ ? 2'd3 : 2'd2);

    // =====================================================================
    // pin direction and buffer enables
    // =====================================================================

    // input buffers follow the mode; all but the strap inputs off until the straps are latched
    always_comb
    begin
        addrInEn  = 15'h0000;
        adInEn    = 16'h0000;
        ctlInEn   = 4'h0;
        strapInEn = 5'h00;
        if (!selDone)
            strapInEn = 5'h1F;  // straps must be readable for the latch
        else if (serialQ)
            strapInEn = PINS64 ? `STRAP_KEEP_SPI64 : 5'h00;
        else
        begin
            ctlInEn[1] = 1'b1;  // read strobe or read/write select
            ctlInEn[2] = 1'b1;  // store, enable, low store or byte0 select
            case (modeQ)
                MODE_1, MODE_2:
                begin
                    addrInEn = 15'h7FFF;
                    adInEn   = 16'h00FF;
                end
                MODE_3, MODE_4:
                begin
                    addrInEn   = 15'h3FFF;
                    adInEn     = 16'hFFFF;
                    ctlInEn[3] = 1'b1;
                end
                MODE_5, MODE_6:
                begin
                    adInEn     = 16'h7FFF;
                    ctlInEn[0] = 1'b1;
                end
                MODE_9, MODE_10:
                begin
                    adInEn     = 16'hFFFF;
                    ctlInEn[0] = 1'b1;
                    ctlInEn[3] = 1'b1;
                end
                default: adInEn = 16'h0000;  // unused pins stay off
            endcase
        end
    end

    logic [15:0] dataMask;  // data lines the mode may drive

    // only the data width of the mode may ever be driven
    always_comb
    begin
        dataMask = wide ? 16'hFFFF : 16'h00FF;
    end

    // drive the shared lines only in a selected read
    assign adOe = (parOn && csPin && parReadDrive) ? dataMask : 16'h0000;

    // serial output released whenever chip select is high
    assign soOe    = selDone && serialQ && !csPin && spiSoDrive;
    assign spiInEn = selDone && serialQ;

    // chip select polarity and pulls
    assign csPullUpEn   = selDone && serialQ;
    assign csPullDownEn = selDone && !serialQ;
    assign csActive     = selDone && (serialQ ? !csPin : csPin);

    // data outputs from flops
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            soOut <= 1'b0;
            adOut <= 16'h0000;
        end
        else
        begin
            soOut <= spiSoData;
            adOut <= parReadData & dataMask;
        end
    end

    // =====================================================================
    // control register address decode
    // =====================================================================

    logic [8:0] regLin;  // linear register address, one bit wider to catch overflow

    // banked form is bank times 32 plus the low five bits
    always_comb
    begin
        if (regUnbanked)
            regLin = {1'b0, regAddr};
        else
            regLin = 9'({regBank, regAddr[4:0]});
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            regLinearQ <= 8'h00;
            regHitQ    <= 1'b0;
        end
        else
        begin
            regLinearQ <= regLin[7:0];
            regHitQ    <= selDone && serialQ && (regLin < `REG_SPACE_BYTES);
        end
    end

    // =====================================================================
    // main memory and phy decode
    // =====================================================================

    logic [15:0] byteAddr;  // byte address after width scaling
    region_t     memRegion;
    logic        memOk;

    // wide parallel modes address words on the bus
    always_comb
    begin
        if (!memFromDma && memDirect && wideData)
            byteAddr = {memAddr[14:0], 1'b0};
        else
            byteAddr = {1'b0, memAddr[14:0]};
        memRegion = regionOf(byteAddr, serialQ);
        memOk     = selDone && memReq;
        if (memRegion == REG_CRYPTO && !memFromDma)
            memOk = 1'b0;
        if (memDirect && !memFromDma && serialQ)
            memOk = 1'b0;  // direct access only on parallel
        if (memRegion == REG_UNUSED)
            memOk = 1'b0;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            memRegionQ <= REG_NONE;
            sramWordQ  <= 14'h0000;
            sramLaneQ  <= 2'h0;
            memGrantQ  <= 1'b0;
            memDenyQ   <= 1'b0;
        end
        else
        begin
            memRegionQ <= memReq ? memRegion : REG_NONE;
            sramWordQ  <= byteAddr[14:1];
            // word access in wide direct mode, single byte lane otherwise
            if (!memFromDma && memDirect && wideData)
                sramLaneQ <= 2'h3;
            else
                sramLaneQ <= byteAddr[0] ? 2'h2 : 2'h1;
            memGrantQ <= memOk;
            memDenyQ  <= memReq && !memOk;
        end
    end

    // phy space answers only the management path
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            phyGrantQ <= 1'b0;
            phyDenyQ  <= 1'b0;
        end
        else
        begin
            phyGrantQ <= selDone && phyReq && phyFromMgmt && (phyAddr < `PHY_WORDS);
            phyDenyQ  <= phyReq && !(selDone && phyFromMgmt && (phyAddr < `PHY_WORDS));
        end
    end

    // =====================================================================
    // checks
    // =====================================================================

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_so_released: assert property (csPin |-> !soOe)
        else $error("serial output driven while deselected");
    chk_serial_pins_off: assert property (selDone && serialQ |-> adInEn == 16'h0000 && addrInEn == 15'h0000 && adOe == 16'h0000)
        else $error("parallel pin active in serial mode");
    chk_latch_timing: assert property ($rose(selDone) |-> $past(stateQ) == ST_LATCH && $past(delayCntQ, 2) == 6'(DELAY_CYC - 1))
        else $error("straps latched at the wrong time");
    chk_choice_held: assert property (selDone |=> $stable(serialQ) && $stable(modeQ))
        else $error("latched selection changed");
    chk_strap_choice: assert property (stateQ == ST_LATCH |=> serialQ == $past(interfaceSelectStrap))
        else $error("interface strap misread");
    chk_mode_decode: assert property (stateQ == ST_LATCH && !interfaceSelectStrap |=> modeQ == decodeMode(PINS64, $past(parallelModeStraps)))
        else $error("parallel mode misdecoded");
    chk_ad_input: assert property (!csPin |-> adOe == 16'h0000)
        else $error("shared lines driven while deselected");
    chk_cs_pulls: assert property (selDone |-> csPullUpEn == serialQ && csPullDownEn == !serialQ)
        else $error("chip select pull wrong");
    chk_crypto_denied: assert property (memReq && !memFromDma && memRegion == REG_CRYPTO |=> memDenyQ && !memGrantQ)
        else $error("host reached crypto memory");
    chk_phy_host_denied: assert property (phyReq && !phyFromMgmt |=> !phyGrantQ ##1 1'b1)
        else $error("host reached phy space");
    chk_narrow_drive: assert property (parOn && !wide |-> adOe[15:8] == 8'h00)
        else $error("narrow mode drove upper lines");

    cov_serial_sel: cover property ($rose(selDone) && serialQ);
    cov_wide_read:  cover property (parOn && wide && adOe == 16'hFFFF);
    cov_mode10:     cover property (selDone && modeQ == MODE_10);
    cov_crypto_dma: cover property (memReq && memFromDma && memRegion == REG_CRYPTO);

endmodule

// File: hw/host_if_params.svh
// timing, address map and strap constants for the host interface selector
`ifndef HOST_IF_PARAMS_SVH
`define HOST_IF_PARAMS_SVH

// clock and strap latch timing
`define CLK_PERIOD_NS      40
`define STRAP_DELAY_NS     1000
`define STRAP_DELAY_CYC    ((`STRAP_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// control register space
`define REG_SPACE_BYTES    9'd160
`define REG_BANK_BYTES     9'd32

// main memory map (byte addresses)
`define SRAM_LAST          16'h5FFF
`define CRYPTO_FIRST       16'h7800
`define CRYPTO_LAST        16'h7C4F
`define PAR_REG_BASE       16'h7E00

// phy register space
`define PHY_WORDS          6'd32

// strap positions on the parallel mode strap group
`define STRAP_BIT0         0
`define STRAP_BIT1         1
`define STRAP_BIT2         2
`define STRAP_BIT3         3
`define STRAP_BIT4         4
`define STRAP_KEEP_SPI64   5'h0C

`endif

// File: hw/host_if_pkg.sv
// types shared by the host interface selector
package host_if_pkg;

    // selected interface mode; 0 means serial, others are parallel mode numbers
    typedef enum logic [3:0] {
        MODE_SERIAL = 4'h0,
        MODE_1      = 4'h1,
        MODE_2      = 4'h2,
        MODE_3      = 4'h3,
        MODE_4      = 4'h4,
        MODE_5      = 4'h5,
        MODE_6      = 4'h6,
        MODE_9      = 4'h9,
        MODE_10     = 4'hA
    } mode_t;

    // strap latch sequence
    typedef enum logic [2:0] {
        ST_WAIT  = 3'b001,
        ST_LATCH = 3'b010,
        ST_RUN   = 3'b100
    } state_t;

    // main memory regions
    typedef enum logic [2:0] {
        REG_NONE   = 3'h0,
        REG_SRAM   = 3'h1,
        REG_CRYPTO = 3'h2,
        REG_CTRL   = 3'h3,
        REG_UNUSED = 3'h4
    } region_t;

endpackage

// File: verification/host_model.sv
// host side strap drivers for the interface selector
`timescale 1ns/1ps

module host_model
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // wanted strap levels and latch status
    input  wire logic       wantSerial,
    input  wire logic [4:0] wantStraps,
    input  wire logic       selDone,
    // strap pins
    output logic            interfaceSelectStrap,
    output logic [4:0]      parallelModeStraps
);
    // =====================================================
    // strap wander
    logic flip_q;  // toggles every cycle once latched

    // a real board may reuse strap pins afterwards, so keep them moving
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            flip_q <= 1'b0;
        else
            flip_q <= selDone ? ~flip_q : 1'b0;
    end

    // wanted levels stand until latched, then change each cycle
    assign interfaceSelectStrap = wantSerial ^ flip_q;
    assign parallelModeStraps   = wantStraps ^ {5{flip_q}};
endmodule

// File: verification/testbench.sv
// self-checking bench for the host interface selector, both pin variants
`timescale 1ns/1ps

module testbench
    import host_if_pkg::*;
;
    // =====================================================
    // signals
    logic clk, resetn, wantSerial, csPin, spiSoDrive, spiSoData, parReadDrive;
    logic regUnbanked, memReq, memFromDma, memDirect, phyReq, phyFromMgmt;
    logic interfaceSelectStrap;
    logic [4:0]  wantStraps, parallelModeStraps;
    logic [15:0] parReadData, memAddr;
    logic [1:0]  regBank;
    logic [7:0]  regAddr;
    logic [5:0]  phyAddr;
    // outputs: index 0 is the 64-pin part, index 1 the 44-pin part
    logic soOut[2], soOe[2], spiInEn[2], csPullUpEn[2], csPullDownEn[2], csActive[2], selDone[2];
    logic serialMode[2], wideData[2], muxedBus[2], rwSelectStyle[2], regHitQ[2];
    logic memGrantQ[2], memDenyQ[2], phyGrantQ[2], phyDenyQ[2];
    logic [15:0] adOut[2], adOe[2], adInEn[2];
    logic [14:0] addrInEn[2];
    logic [3:0]  ctlInEn[2];
    logic [4:0]  strapInEn[2];
    logic [1:0]  addrSpaces[2], sramLaneQ[2];
    logic [7:0]  regLinearQ[2];
    logic [13:0] sramWordQ[2];
    mode_t       modeSel[2];
    region_t     memRegionQ[2];
    int          n_fail, num_checks, cycles;

    // =====================================================
    // design and host
    host_model u_host (.clk(clk), .resetn(resetn), .wantSerial(wantSerial), .wantStraps(wantStraps),
        .selDone(selDone[0]), .interfaceSelectStrap(interfaceSelectStrap),
        .parallelModeStraps(parallelModeStraps));

    for (genvar g = 0; g < 2; g++)
    begin : gen_dut
        host_if_select #(.PINS64(g == 0)) u_dut (.clk(clk), .resetn(resetn),
            .interfaceSelectStrap(interfaceSelectStrap), .parallelModeStraps(parallelModeStraps),
            .csPin(csPin), .spiSoDrive(spiSoDrive), .spiSoData(spiSoData), .soOut(soOut[g]),
            .soOe(soOe[g]), .spiInEn(spiInEn[g]), .csPullUpEn(csPullUpEn[g]),
            .csPullDownEn(csPullDownEn[g]), .csActive(csActive[g]), .parReadDrive(parReadDrive),
            .parReadData(parReadData), .adOut(adOut[g]), .adOe(adOe[g]), .adInEn(adInEn[g]),
            .addrInEn(addrInEn[g]), .ctlInEn(ctlInEn[g]), .strapInEn(strapInEn[g]),
            .selDone(selDone[g]), .serialMode(serialMode[g]), .modeSel(modeSel[g]),
            .wideData(wideData[g]), .muxedBus(muxedBus[g]), .rwSelectStyle(rwSelectStyle[g]),
            .addrSpaces(addrSpaces[g]), .regUnbanked(regUnbanked), .regBank(regBank),
            .regAddr(regAddr), .regLinearQ(regLinearQ[g]), .regHitQ(regHitQ[g]), .memReq(memReq),
            .memFromDma(memFromDma), .memDirect(memDirect), .memAddr(memAddr),
            .memRegionQ(memRegionQ[g]), .sramWordQ(sramWordQ[g]), .sramLaneQ(sramLaneQ[g]),
            .memGrantQ(memGrantQ[g]), .memDenyQ(memDenyQ[g]), .phyReq(phyReq),
            .phyFromMgmt(phyFromMgmt), .phyAddr(phyAddr), .phyGrantQ(phyGrantQ[g]),
            .phyDenyQ(phyDenyQ[g]));
    end

    // =====================================================
    // helpers
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // reset for five cycles, then wait out the strap latch delay
    task automatic boot(input logic ser, input logic [4:0] st);
        @(posedge clk);
        resetn <= 1'b0;
        wantSerial <= ser;
        wantStraps <= st;
        repeat (5) @(posedge clk);
        chk("strapInEn reset", strapInEn[0], 32'h1F);
        chk("serialMode reset", serialMode[0], 32'h1);
        resetn <= 1'b1;
        repeat (25) @(posedge clk);
        #1;
        chk("selDone early", selDone[0], 32'h0);
        @(posedge clk);
        #1;
        chk("selDone", selDone[0], 32'h1);
    endtask

    // hold chip select and drive requests over one sampling edge
    task automatic pins(input logic cs, input logic rd);
        @(posedge clk);
        csPin <= cs;
        parReadDrive <= rd;
        spiSoDrive <= rd;
        spiSoData <= rd;
        @(posedge clk);
        #1;
    endtask

    task automatic regChk(input logic u, input logic [1:0] b, input logic [7:0] a, input logic [7:0] lin,
                          input logic hit);
        @(posedge clk);
        regUnbanked <= u;
        regBank <= b;
        regAddr <= a;
        @(posedge clk);
        #1;
        chk("regLinearQ", regLinearQ[0], lin);
        chk("regHitQ", regHitQ[0], hit);
    endtask

    // one-cycle request; region, word and lanes only judged when granted
    task automatic memChk(input logic dma, input logic dir, input logic [15:0] a, input logic gnt,
                          input region_t rg, input logic [13:0] w, input logic [1:0] ln);
        @(posedge clk);
        memReq <= 1'b1;
        memFromDma <= dma;
        memDirect <= dir;
        memAddr <= a;
        @(posedge clk);
        memReq <= 1'b0;
        #1;
        chk("memGrantQ", {memGrantQ[0], memDenyQ[0]}, {gnt, ~gnt});
        if (gnt)
            chk("memRegionQ", memRegionQ[0], rg);
        if (gnt && rg == REG_SRAM)
            chk("sramWord", {sramWordQ[0], sramLaneQ[0]}, {w, ln});
    endtask

    task automatic phyChk(input logic mg, input logic [5:0] a, input logic gnt);
        @(posedge clk);
        phyReq <= 1'b1;
        phyFromMgmt <= mg;
        phyAddr <= a;
        @(posedge clk);
        phyReq <= 1'b0;
        #1;
        chk("phyAnswer", {phyGrantQ[0], phyDenyQ[0]}, {gnt, ~gnt});
    endtask

    function automatic logic [15:0] adMask(input mode_t m);
        if (m == MODE_3 || m == MODE_4 || m == MODE_9 || m == MODE_10)
            return 16'hFFFF;
        return (m >= MODE_5) ? 16'h7FFF : 16'h00FF;
    endfunction

    // =====================================================
    // scenarios
    task automatic t_modes();
        logic [4:0] st [8] = '{5'h02, 5'h11, 5'h04, 5'h17, 5'h18, 5'h0B, 5'h0C, 5'h1F};
        mode_t md [8] = '{MODE_1, MODE_2, MODE_3, MODE_4, MODE_5, MODE_6, MODE_9, MODE_10};
        for (int i = 0; i < 8; i++)
        begin
            boot(1'b0, st[i]);
            chk("modeSel64", modeSel[0], md[i]);
            chk("modeSel44", modeSel[1], st[i][0] ? MODE_6 : MODE_5);
            chk("adInEn", adInEn[0], adMask(md[i]));
            chk("addrInEn", addrInEn[0], md[i] < MODE_3 ? 15'h7FFF : md[i] < MODE_5 ? 15'h3FFF : 15'h0);
            chk("ctlInEn", ctlInEn[0], {adMask(md[i]) == 16'hFFFF, 2'b11, md[i] >= MODE_5});
            chk("parallel", {serialMode[0], addrSpaces[0], csPullDownEn[0], csPullUpEn[0]}, 5'h0A);
            chk("modeKind", {wideData[0], muxedBus[0], rwSelectStyle[0]},
                {adMask(md[i]) == 16'hFFFF, md[i] >= MODE_5, i[0]});
            chk("strapInEn par", strapInEn[0], 32'h0);
            repeat (10) @(posedge clk);
            #1;
            chk("modeSel kept", modeSel[0], md[i]);
        end
    endtask

    task automatic t_serial();
        boot(1'b1, 5'h0C);
        chk("serial", {serialMode[0], addrSpaces[0], csPullUpEn[0], csPullDownEn[0], spiInEn[0]}, 6'h3D);
        chk("strapKeep64", strapInEn[0], 32'h0C);
        chk("strapKeep44", strapInEn[1], 32'h00);
        chk("parInEn", {adInEn[0], addrInEn[0]}, 32'h0);
        chk("ctlInEn", ctlInEn[0], 32'h0);
        pins(1'b1, 1'b1);
        chk("soOe idle", {soOe[0], csActive[0]}, 2'b00);
        pins(1'b0, 1'b1);
        chk("soOe sel", {soOe[0], csActive[0], soOut[0]}, 3'b111);
        chk("adOe serial", adOe[0], 32'h0);
        regChk(1'b0, 2'd2, 8'h05, 8'h45, 1'b1);
        regChk(1'b0, 2'd3, 8'h1F, 8'h7F, 1'b1);
        regChk(1'b1, 2'd1, 8'h9F, 8'h9F, 1'b1);
        regChk(1'b1, 2'd0, 8'hA0, 8'hA0, 1'b0);
        memChk(1'b0, 1'b0, 16'h0003, 1'b1, REG_SRAM, 14'h0001, 2'b10);
        memChk(1'b0, 1'b0, 16'h5FFE, 1'b1, REG_SRAM, 14'h2FFF, 2'b01);
        memChk(1'b0, 1'b0, 16'h6000, 1'b0, REG_NONE, 14'h0, 2'b00);
        memChk(1'b0, 1'b0, 16'h7800, 1'b0, REG_NONE, 14'h0, 2'b00);
        memChk(1'b1, 1'b0, 16'h7C4F, 1'b1, REG_CRYPTO, 14'h0, 2'b00);
        memChk(1'b1, 1'b0, 16'h7C50, 1'b0, REG_NONE, 14'h0, 2'b00);
        memChk(1'b0, 1'b1, 16'h0003, 1'b0, REG_NONE, 14'h0, 2'b00);
        phyChk(1'b1, 6'h1F, 1'b1);
        phyChk(1'b0, 6'h00, 1'b0);
        phyChk(1'b1, 6'h20, 1'b0);
    endtask

    task automatic t_parallel();
        boot(1'b0, 5'h0C);
        pins(1'b1, 1'b1);
        chk("adOe wide", adOe[0], 32'hFFFF);
        chk("adOe narrow", adOe[1], 32'h00FF);
        chk("adOut", {adOut[0], adOut[1]}, 32'hBEEF00EF);
        chk("par cs", {soOe[0], csActive[0]}, 2'b01);
        pins(1'b0, 1'b1);
        chk("adOe desel", {adOe[0], adOe[1]}, 32'h0);
        regChk(1'b1, 2'd0, 8'h10, 8'h10, 1'b0);
        memChk(1'b0, 1'b1, 16'h0003, 1'b1, REG_SRAM, 14'h0003, 2'b11);
        memChk(1'b0, 1'b0, 16'h0003, 1'b1, REG_SRAM, 14'h0001, 2'b10);
        memChk(1'b0, 1'b1, 16'h3C00, 1'b0, REG_NONE, 14'h0, 2'b00);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // =====================================================
    // clock, watchdog and main sequence
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // the whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            n_fail++;
            end_of_test();
        end
    end

    initial
    begin
        {resetn, wantSerial, csPin, spiSoDrive, spiSoData, parReadDrive} = 6'h0;
        {regUnbanked, memReq, memFromDma, memDirect, phyReq, phyFromMgmt} = 6'h0;
        {wantStraps, regBank, regAddr, phyAddr, memAddr} = 37'h0;
        parReadData = 16'hBEEF;
        {n_fail, num_checks, cycles} = '0;
        t_modes();
        t_serial();
        t_parallel();
        end_of_test();
    end
endmodule
